// ### timer_pin_map.vh
// Offsets, field positions, field codes and timing counts for the timer pin block
// Included by every design file of the block
`ifndef TIMER_PIN_MAP_VH
`define TIMER_PIN_MAP_VH
`define TMR_NUM_CH 8
`define TMR_CNT_W 16
`define TMR_ADDR_W 8
// Global control register: [1:0] clock select, [2] center pwm, [5:3] prescale
`define TMR_REG_CTRL 8'h00
`define TMR_REG_MOD 8'h04
`define TMR_REG_CNT 8'h08
`define TMR_REG_PINS 8'h0c
// Channel registers: control at 0x40 + 8*n, value at 0x44 + 8*n
`define TMR_REG_CH_BASE 8'h40
`define TMR_CTRL_CLK_LO 0
`define TMR_CTRL_CPWM 2
`define TMR_CTRL_PS_LO 3
// Channel control: [1:0] edge/level select, [3:2] mode select, [4] capture/compare flag
`define TMR_CH_ELS_LO 0
`define TMR_CH_MS_LO 2
`define TMR_CH_FLAG 4
`define TMR_CLK_OFF 2'h0
`define TMR_CLK_BUS 2'h1
`define TMR_CLK_FIXED 2'h2
`define TMR_CLK_EXT 2'h3
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`define TMR_SYNC_STAGES 2
`endif

// ### pin_sync.v
// Two-flop synchronizer with registered edge detect behind it
// Assumes an asynchronous level on pin_in
`timescale 1ns/100ps
`include "timer_pin_map.vh"
module pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule // pin_sync

// ### timer_channel.v
// One timer channel: capture, compare and pwm pin logic
// Assumes counter, tick and direction from the parent on the same clock
`timescale 1ns/100ps
`include "timer_pin_map.vh"
module timer_channel (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] edge_level_select,
  input wire [1:0] channel_mode_select,
  input wire center_pwm_select,
  input wire clk_on,
  input wire tick,
  input wire count_down,
  input wire [15:0] timer_counter_value,
  input wire [15:0] channel_match_value,
  input wire cap_rise,
  input wire cap_fall,
  output reg pin_out_ff,
  output reg pin_oe_ff,
  output wire capture
);
  wire els_on = |edge_level_select;
  wire owns = els_on & clk_on;
  wire mode_cap = owns & ~center_pwm_select & (channel_mode_select == 2'h0);
  wire mode_cmp = owns & ~center_pwm_select & (channel_mode_select == 2'h1);
  wire mode_epwm = owns & ~center_pwm_select & channel_mode_select[1];
  wire mode_cpwm = owns & center_pwm_select;
  wire match = tick & (timer_counter_value == channel_match_value);
  wire start = tick & (timer_counter_value == 16'h0000);
  reg nxt_pin;
  // Capture edge choice: 01 rising, 10 falling, 11 any
  assign capture = mode_cap & ((edge_level_select[0] & cap_rise) |
                   (edge_level_select[1] & cap_fall));
  always @* begin
    nxt_pin = pin_out_ff;
    if (mode_cmp & match) begin
      case (edge_level_select)
        2'h1: nxt_pin = ~pin_out_ff;
        2'h2: nxt_pin = 1'b0;
        2'h3: nxt_pin = 1'b1;
        default: nxt_pin = pin_out_ff;
      endcase
    end else if (mode_epwm) begin
      if (match) nxt_pin = edge_level_select[0];
      else if (start) nxt_pin = ~edge_level_select[0];
    end else if (mode_cpwm & match) begin
      nxt_pin = edge_level_select[0] ^ count_down;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin;
      pin_oe_ff <= mode_cmp | mode_epwm | mode_cpwm;
    end
  end
endmodule // timer_channel

// ### timer_channel_pin_control.v
// Timer module with eight channel pins, counter, prescaler and AXI4-Lite slave
// Assumes an external pin-mux that gives pins to the port when enables are low
// How it works
// - Software picks counter clock: off, bus rate, fixed clock or external input.
// - External count clock passes a bus-clock synchronizer before counting.
// - With external clock, a channel still works as pin-less compare timer.
// - Pin stays with the port when edge/level select or clock select is zero.
// - Center pwm select with nonzero edge/level runs every channel center-aligned.
// - Without center pwm, mode select picks capture, compare or edge pwm.
// - Capture forces pin to edge input; edge/level select picks edge polarity.
// - Capture inputs are synchronized; pulses need one bus clock to be seen.
// - Compare drives the pin and toggles, clears or sets it on every match.
// - Toggle mode keeps the previous pin level until the next match.
// - High-true edge pwm goes high at count zero, low on match.
// - Low-true edge pwm goes low at count zero, high on match.
// - High-true center pwm clears on up-count match, sets on down-count match.
// - Low-true center pwm sets on up-count match, clears on down-count match.
// - Eight channels, each with separately addressed controls.
// - Clock select 00 off, 01 bus, 10 fixed, 11 external.
// - Center mode counts up to modulo, then down to zero, repeating.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`include "timer_pin_map.vh"
module timer_channel_pin_control (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire external_count_clock_in,
  input wire fixed_clock_tick,
  input wire [7:0] channel_pin_in,
  output wire [7:0] channel_pin_out,
  output wire [7:0] channel_pin_oe
);
  reg [1:0] counter_clock_select_ff;
  reg center_pwm_select_ff;
  reg [2:0] prescale_ff;
  reg [15:0] counter_modulo_value_ff;
  reg [15:0] timer_counter_value_ff;
  reg count_down_ff;
  reg [6:0] div_ff;
  reg [4:0] ch_ctrl_ff [0:7];
  reg [15:0] channel_match_value_ff [0:7];
  reg [7:0] aw_addr_ff;
  reg aw_have_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg w_have_ff;
  reg ext_last_ff;
  wire ext_level;
  wire [7:0] cap_rise;
  wire [7:0] cap_fall;
  wire [7:0] cap_evt;
  wire [7:0] pin_level;

  pin_sync u_ext_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(external_count_clock_in),
    .level(ext_level),
    .rise(),
    .fall()
  );

  // Clock source decode feeding the prescaler
  reg src_tick;
  always @* begin
    case (counter_clock_select_ff)
      `TMR_CLK_BUS: src_tick = 1'b1;
      `TMR_CLK_FIXED: src_tick = fixed_clock_tick;
      `TMR_CLK_EXT: src_tick = ext_level & ~ext_last_ff;
      default: src_tick = 1'b0;
    endcase
  end
  wire clk_on = counter_clock_select_ff != `TMR_CLK_OFF;
  wire [6:0] div_mask = (7'h01 << prescale_ff) - 7'h01;
  wire tick = src_tick & ((div_ff & div_mask) == div_mask);

  // Write and read channel handshake and decode
  wire wr_fire = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  wire wr_ch = aw_addr_ff[7:6] == 2'h1;
  wire [2:0] wr_idx = aw_addr_ff[5:3];
  wire wr_cnt = wr_fire & (aw_addr_ff == `TMR_REG_CNT);
  wire wr_ctrl = wr_fire & (aw_addr_ff == `TMR_REG_CTRL) & w_strb_ff[0];
  wire wr_mod = wr_fire & (aw_addr_ff == `TMR_REG_MOD);
  wire wr_ok = (aw_addr_ff == `TMR_REG_CTRL) || (aw_addr_ff == `TMR_REG_MOD) ||
               (aw_addr_ff == `TMR_REG_CNT) || (aw_addr_ff == `TMR_REG_PINS) ||
               (wr_ch && aw_addr_ff[1:0] == 2'h0);
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire rd_ch = s_axi_araddr[7:6] == 2'h1;
  wire [2:0] rd_idx = s_axi_araddr[5:3];
  wire [31:0] rd_ch_word = s_axi_araddr[2] ? {16'h0000, channel_match_value_ff[rd_idx]} :
                           {27'h0000000, ch_ctrl_ff[rd_idx]};

  // Counter: up-count with wrap, or up/down in center mode
  reg [15:0] nxt_cnt;
  reg nxt_down;
  always @* begin
    nxt_cnt = timer_counter_value_ff;
    nxt_down = count_down_ff;
    if (wr_cnt) begin
      nxt_cnt = 16'h0000;
      nxt_down = 1'b0;
    end else if (tick) begin
      if (center_pwm_select_ff) begin
        if (!count_down_ff && timer_counter_value_ff >= counter_modulo_value_ff) begin
          nxt_down = 1'b1;
          nxt_cnt = timer_counter_value_ff - 16'h0001;
        end else if (count_down_ff && timer_counter_value_ff == 16'h0000) begin
          nxt_down = 1'b0;
          nxt_cnt = 16'h0001;
        end else if (count_down_ff) begin
          nxt_cnt = timer_counter_value_ff - 16'h0001;
        end else begin
          nxt_cnt = timer_counter_value_ff + 16'h0001;
        end
      end else if (counter_modulo_value_ff != 16'h0000 &&
                   timer_counter_value_ff == counter_modulo_value_ff) begin
        nxt_cnt = 16'h0000;
        nxt_down = 1'b0;
      end else begin
        nxt_cnt = timer_counter_value_ff + 16'h0001;
        nxt_down = 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_counter_value_ff <= 16'h0000;
      count_down_ff <= 1'b0;
      div_ff <= 7'h00;
      ext_last_ff <= 1'b0;
    end else begin
      timer_counter_value_ff <= nxt_cnt;
      count_down_ff <= nxt_down;
      ext_last_ff <= ext_level;
      if (wr_cnt || !clk_on) div_ff <= 7'h00;
      else if (src_tick) div_ff <= div_ff + 7'h01;
    end
  end

  // Channels
  genvar g;
  generate
    for (g = 0; g < `TMR_NUM_CH; g = g + 1) begin : g_ch
      pin_sync u_cap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(channel_pin_in[g]),
        .level(pin_level[g]),
        .rise(cap_rise[g]),
        .fall(cap_fall[g])
      );
      timer_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .edge_level_select(ch_ctrl_ff[g][1:0]),
        .channel_mode_select(ch_ctrl_ff[g][3:2]),
        .center_pwm_select(center_pwm_select_ff),
        .clk_on(clk_on),
        .tick(tick),
        .count_down(count_down_ff),
        .timer_counter_value(timer_counter_value_ff),
        .channel_match_value(channel_match_value_ff[g]),
        .cap_rise(cap_rise[g]),
        .cap_fall(cap_fall[g]),
        .pin_out_ff(channel_pin_out[g]),
        .pin_oe_ff(channel_pin_oe[g]),
        .capture(cap_evt[g])
      );
      // Per-channel write strobes and the pin-less compare hit
      wire ctl_we = wr_fire && wr_ch && wr_idx == g && !aw_addr_ff[2] && w_strb_ff[0];
      wire val_we = wr_fire && wr_ch && wr_idx == g && aw_addr_ff[2];
      wire cmp_hit = tick && !center_pwm_select_ff && ch_ctrl_ff[g][3:2] == 2'h1 &&
                     timer_counter_value_ff == channel_match_value_ff[g];
      // Capture, flag and software writes per channel; capture set beats clear
      always @(posedge aclk) begin
        if (!aresetn) begin
          ch_ctrl_ff[g] <= 5'h00;
          channel_match_value_ff[g] <= 16'h0000;
        end else begin
          if (ctl_we)
            ch_ctrl_ff[g] <= {ch_ctrl_ff[g][4] & w_data_ff[4], w_data_ff[3:0]};
          if (val_we) begin
            if (w_strb_ff[0]) channel_match_value_ff[g][7:0] <= w_data_ff[7:0];
            if (w_strb_ff[1]) channel_match_value_ff[g][15:8] <= w_data_ff[15:8];
          end
          // Hardware hits come last so they win over a software clear
          if (cmp_hit)
            ch_ctrl_ff[g][4] <= 1'b1;
          if (cap_evt[g]) begin
            channel_match_value_ff[g] <= timer_counter_value_ff;
            ch_ctrl_ff[g][4] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Global control and modulo registers, loaded at the edge that raises bvalid
  always @(posedge aclk) begin
    if (!aresetn) begin
      counter_clock_select_ff <= 2'h0;
      center_pwm_select_ff <= 1'b0;
      prescale_ff <= 3'h0;
      counter_modulo_value_ff <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        counter_clock_select_ff <= w_data_ff[`TMR_CTRL_CLK_LO +: 2];
        center_pwm_select_ff <= w_data_ff[`TMR_CTRL_CPWM];
        prescale_ff <= w_data_ff[`TMR_CTRL_PS_LO +: 3];
      end
      if (wr_mod) begin
        if (w_strb_ff[0]) counter_modulo_value_ff[7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) counter_modulo_value_ff[15:8] <= w_data_ff[15:8];
      end
    end
  end

  // AXI4-Lite slave handshake and read data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      aw_addr_ff <= 8'h00;
      aw_have_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      w_have_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_have_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TMR_RESP_OKAY;
        if (rd_ch && s_axi_araddr[1:0] == 2'h0)
          s_axi_rdata <= rd_ch_word;
        else begin
          case (s_axi_araddr)
            `TMR_REG_CTRL: s_axi_rdata <= {26'h0000000, prescale_ff,
                                           center_pwm_select_ff, counter_clock_select_ff};
            `TMR_REG_MOD: s_axi_rdata <= {16'h0000, counter_modulo_value_ff};
            `TMR_REG_CNT: s_axi_rdata <= {15'h0000, count_down_ff, timer_counter_value_ff};
            `TMR_REG_PINS: s_axi_rdata <= {16'h0000, channel_pin_oe, pin_level};
            default: begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= `TMR_RESP_SLVERR;
            end
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // timer_channel_pin_control

// ### timer_pin_props.sv
// Bus and pin-ownership checks for the timer pin block
// Assumes bind to the top module; all checks on aclk, reset low disables
`timescale 1ns/100ps
module timer_pin_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] channel_pin_out,
  input wire [7:0] channel_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ar_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_hs;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  read_answer_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_answer_a: assert property (aw_hs and (s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  bad_addr_a: assert property (ar_hs ##0 s_axi_araddr == 8'h10 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  ready_back_a: assert property (r_done |=> s_axi_arready)
    else $error("read ready not restored");
  write_ready_a: assert property (aw_hs |=> !s_axi_awready ##[1:2] s_axi_awready)
    else $error("write ready wrong");
  reset_idle_a: assert property ($rose(aresetn) |-> channel_pin_oe == 8'h00)
    else $error("pin driven after reset");
  pin_take_a: assert property ((channel_pin_oe & ~$past(channel_pin_oe)) != 8'h00
    |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pin taken without write");
endmodule // timer_pin_props
bind timer_channel_pin_control timer_pin_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .channel_pin_out, .channel_pin_oe);

// ### pin_stim_model.sv
// Far-side sources: external count clock, fixed clock tick, pulse on pin 5
// Assumes aclk from the bench; external clock unrelated in phase
`timescale 1ns/100ps
module pin_stim_model (
  input wire aclk,
  input wire ext_run,
  input wire fix_run,
  input wire pulse_go,
  output reg [7:0] pin_lvl_ff,
  output reg ext_clk_ff,
  output reg fix_tick_ff
);
  reg [2:0] div_ff;
  reg [2:0] hold_ff;
  initial begin
    pin_lvl_ff = 8'h00;
    ext_clk_ff = 1'b0;
    fix_tick_ff = 1'b0;
    div_ff = 3'h0;
    hold_ff = 3'h0;
  end
  // 18 ns period on its own pin, still when off
  always #9 ext_clk_ff = ext_run ? ~ext_clk_ff : 1'b0;
  always @(posedge aclk) begin
    div_ff <= div_ff + 3'h1;
    fix_tick_ff <= fix_run && div_ff == 3'h7;
    if (pulse_go) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
    // Pulse held four bus clocks
    pin_lvl_ff <= {2'h0, pulse_go || hold_ff > 3'h1, 5'h00};
  end
endmodule // pin_stim_model

// ### test_timer_channel_pin_control.sv
// Testbench for the timer pin block over AXI4-Lite
// Assumes the far-side model and the bound checker
`timescale 1ns/100ps
module test_timer_channel_pin_control;
  reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  reg s_axi_bready = 1, s_axi_rready = 1, ext_run = 0, fix_run = 0, pulse_go = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0, d, a;
  reg [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire external_count_clock_in, fixed_clock_tick;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] channel_pin_in, channel_pin_out, channel_pin_oe, lvl;
  reg [2:0] rr;
  int bad_count = 0, comparisons = 0;
  reg [31:0] hi[8], tg[8];
  reg [7:0] ctl[6] = '{8'h0a, 8'h09, 8'h05, 8'h07, 8'h06, 8'h01};
  reg [7:0] sel[5] = '{8'h00, 8'h01, 8'h09, 8'h02, 8'h03};
  reg [15:0] lo[5] = '{16'h0, 16'd40, 16'd19, 16'd4, 16'd8};
  reg [15:0] up[5] = '{16'h0, 16'd48, 16'd25, 16'd7, 16'd12};
  assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & lvl);
  always #2 aclk = ~aclk;
  timer_channel_pin_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_clock_in,
    .fixed_clock_tick, .channel_pin_in, .channel_pin_out, .channel_pin_oe);
  pin_stim_model far (.aclk, .ext_run, .fix_run, .pulse_go, .pin_lvl_ff(lvl),
    .ext_clk_ff(external_count_clock_in), .fix_tick_ff(fixed_clock_tick));
  task automatic chk(input [35:0] got, input [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] ad, input [31:0] wd, input [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask
  task automatic rd(input [7:0] ad, output [31:0] rv);
    int n;
    n = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rv = s_axi_rdata;
    rr = {s_axi_rvalid, s_axi_rresp};
  endtask
  task automatic rdc(input [7:0] ad, input [31:0] exp);
    reg [31:0] v;
    rd(ad, v);
    chk(v, exp);
  endtask
  task automatic sample(input int cyc);
    reg [7:0] p;
    hi = '{default: 0};
    tg = '{default: 0};
    p = channel_pin_out;
    repeat (cyc) begin
      @(posedge aclk);
      for (int k = 0; k < 8; k++) begin
        hi[k] += channel_pin_out[k];
        tg[k] += (channel_pin_out[k] != p[k]);
      end
      p = channel_pin_out;
    end
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({channel_pin_oe, channel_pin_out}, 16'h0);
    rdc(8'h00, 0);
    rd(8'h10, d);
    chk({rr, d}, 35'h6_0000_0000);
    wr(8'h10, 1, 2'h2);
    wr(8'h04, 8, 0);
    for (int k = 0; k < 6; k++) begin
      wr(8'h40 + 8'(8 * k), ctl[k], 0);
      wr(8'h44 + 8'(8 * k), 5, 0);
    end
    wr(8'h00, 1, 0);
    repeat (20) @(posedge aclk);
    sample(18);
    chk(hi[0], 10);
    chk(hi[1], 8);
    chk(tg[2], 2);
    chk(channel_pin_out[4:3], 2'b01);
    chk(channel_pin_oe[5:0], 6'h1f);
    pulse_go <= 1'b1;
    @(posedge aclk);
    pulse_go <= 1'b0;
    repeat (10) @(posedge aclk);
    rdc(8'h68, 8'h11);
    wr(8'h68, 1, 0);
    rdc(8'h68, 8'h01);
    wr(8'h00, 5, 0);
    repeat (40) @(posedge aclk);
    sample(32);
    for (int k = 0; k < 5; k++) chk(hi[k], ctl[k][0] ? 12 : 20);
    wr(8'h04, 0, 0);
    wr(8'h74, 3, 0);
    for (int i = 0; i < 5; i++) begin
      if (sel[i] == 8'h03) wr(8'h70, 4, 0);
      wr(8'h00, sel[i], 0);
      ext_run <= sel[i] == 8'h03;
      fix_run <= sel[i] == 8'h02;
      wr(8'h08, 0, 0);
      rd(8'h08, a);
      repeat (40) @(posedge aclk);
      rd(8'h08, d);
      d = d - a;
      chk((d[15:0] >= lo[i] && d[15:0] <= up[i]) ? lo[i] : d[15:0], lo[i]);
      if (i == 0) chk(channel_pin_oe, 8'h00);
    end
    rdc(8'h70, 8'h14);
    chk(channel_pin_oe[6], 1'b0);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop;
  end
endmodule // test_timer_channel_pin_control
